// [common/pps_pkg.sv]
// Constants, register map and state types of the process PID supervisor.
// Assumes a 10 MHz system clock and an AXI4-Lite register bus.
package pps_pkg;
   localparam int CLK_NS     = 100;
   localparam int SAMPLE_NS  = 1_000_000;
   localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
   localparam int NCFG       = 25;
   // Register indices, byte address is four times the index
   localparam logic [4:0] REG_CTRL   = 5'h00;
   localparam logic [4:0] REG_SEL    = 5'h01;
   localparam logic [4:0] REG_TGT    = 5'h02;
   localparam logic [4:0] REG_FBGAIN = 5'h03;
   localparam logic [4:0] REG_P1     = 5'h04;
   localparam logic [4:0] REG_I1     = 5'h05;
   localparam logic [4:0] REG_D1     = 5'h06;
   localparam logic [4:0] REG_P2     = 5'h07;
   localparam logic [4:0] REG_I2     = 5'h08;
   localparam logic [4:0] REG_D2     = 5'h09;
   localparam logic [4:0] REG_BIAS   = 5'h0a;
   localparam logic [4:0] REG_LPF    = 5'h0b;
   localparam logic [4:0] REG_ILIM   = 5'h0c;
   localparam logic [4:0] REG_OLIM   = 5'h0d;
   localparam logic [4:0] REG_OGAIN  = 5'h0e;
   localparam logic [4:0] REG_RAMP   = 5'h0f;
   localparam logic [4:0] REG_LOSSLV = 5'h10;
   localparam logic [4:0] REG_LOSST  = 5'h11;
   localparam logic [4:0] REG_FALLBK = 5'h12;
   localparam logic [4:0] REG_SLPF   = 5'h13;
   localparam logic [4:0] REG_SLPT   = 5'h14;
   localparam logic [4:0] REG_WAKF   = 5'h15;
   localparam logic [4:0] REG_WAKT   = 5'h16;
   localparam logic [4:0] REG_TLIM   = 5'h17;
   localparam logic [4:0] REG_DISP   = 5'h18;
   localparam logic [4:0] REG_STAT   = 5'h19;
   localparam logic [4:0] REG_FREQ   = 5'h1a;
   localparam logic [4:0] REG_DFB    = 5'h1b;
   // Field positions
   localparam int CTRL_EN   = 0;
   localparam int CTRL_POL  = 1;
   localparam int CTRL_DFB  = 2;
   localparam int CTRL_ADDT = 3;
   localparam int SEL_LOSS  = 0;
   localparam int SEL_SLP   = 2;
   localparam int SEL_GAIN  = 4;
   localparam int SEL_TSRC  = 6;
   localparam int SEL_FSRC  = 9;
   localparam int SEL_REV   = 11;
   localparam logic [2:0] TSRC_REG = 3'h4;
   // Reset values
   localparam logic [31:0] RST_SEL   = 32'h0000_0440;
   localparam logic [31:0] RST_UNITY = 32'h0000_0100;
   localparam logic [31:0] RST_FULL  = 32'h0000_2710;
   localparam logic [31:0] RST_TLIM  = 32'h2710_0000;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;

   typedef enum logic {PPS_AWAKE, PPS_ASLEEP} pps_sleep_e;

   typedef struct packed {
      logic [NCFG-1:0][31:0] cfg;
      logic                  awh, wh, awrdy, wrdy, bvalid, arrdy, rvalid;
      logic [4:0]            wa;
      logic [31:0]           wd, rdata;
      logic [3:0]            ws;
      logic [1:0]            bresp, rresp;
      logic [15:0]           tick, loss_cnt, slp_cnt, freq, disp, fref;
      logic signed [15:0]    tgt, fb, integ, dprev, filt;
      logic                  rev, warn, fault, run, alarm;
      pps_sleep_e            st;
   } pps_state_s;
endpackage

// [verif/pps_drive_model.sv]
// Far side of the supervisor: feedback/target sampler and drive ramp.
// Assumes one clock shared with the supervisor and a sync high reset.
`timescale 1ns/1ps
module pps_drive_model #(
   parameter logic [15:0] STEP = 16'h0064
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] freq_ref,
   input  wire logic        run_cmd,
   input  wire logic [15:0] fb_level,
   input  wire logic [15:0] tgt_level,
   input  wire logic [15:0] base_level,
   output logic      [15:0] fb_sample,
   output logic      [15:0] tgt_sample,
   output logic      [15:0] base_freq,
   output logic      [15:0] motor_freq
);
   logic [15:0] aim;
   assign aim = run_cmd ? freq_ref : 16'h0000;
   // Sampler delivers fresh values every clock
   always_ff @(posedge clk) begin
      if (rst) begin
         fb_sample  <= 16'h0000;
         tgt_sample <= 16'h0000;
         base_freq  <= 16'h0000;
         motor_freq <= 16'h0000;
      end else begin
         fb_sample  <= fb_level;
         tgt_sample <= tgt_level;
         base_freq  <= base_level;
         if (aim > motor_freq + STEP)
            motor_freq <= motor_freq + STEP;
         else if (aim + STEP < motor_freq)
            motor_freq <= motor_freq - STEP;
         else
            motor_freq <= aim;
      end
   end
endmodule

// [verif/tb.sv]
// Self-checking bench of the PID supervisor over AXI4-Lite.
// Assumes pps_pkg register map and a short control sample period.
`timescale 1ns/1ps
module tb;
   import pps_pkg::*;
   localparam int          SC = 8;
   localparam logic [31:0] B  = 32'h0000_0440;
   logic        clk = 1'b0, sys_rst = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000, rdata, rdat;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [15:0] fb_level = 16'h0000, tgt_level = 16'h1f40;
   logic [15:0] base_level = 16'h0000;
   logic [15:0] fb_s, tgt_s, base_f, freq_ref, disp_fb, motor_f;
   logic        di_ramp_off = 1'b1, di_gain_alt = 1'b0;
   logic        di_sleep_en = 1'b0, rtc_active = 1'b0;
   logic        reverse, run_cmd, fault_contact, loss_warn;
   logic        loss_fault, src_alarm, sleeping;
   int          n_mismatch = 0, n_checks = 0;
   logic [4:0]  ri [6] = '{REG_SEL, REG_FBGAIN, REG_ILIM, REG_OLIM,
                           REG_OGAIN, REG_TLIM};
   logic [31:0] rv [6] = '{RST_SEL, RST_UNITY, RST_FULL, RST_FULL,
                           RST_UNITY, RST_TLIM};
   logic [4:0]  ci [8] = '{REG_P1, REG_I1, REG_D1, REG_P2, REG_I2,
                           REG_D2, REG_BIAS, REG_LPF};
   logic [31:0] cv [8] = '{32'h0000_0100, 32'h0000_0000, 32'h0000_0000,
                           32'h0000_0080, 32'h0000_0000, 32'h0000_0000,
                           32'h0000_0000, 32'h0000_0100};
   logic [1:0]  gm [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
   logic        gd [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   logic        gr [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   logic [15:0] ge [5] = '{16'h1388, 16'h09c4, 16'h1388, 16'h09c4, 16'h09c4};

   always #50 clk = ~clk;

   pps_top #(.SAMPLE_CYC(SC)) DUT (
      .CLK(clk), .SYS_RST(sys_rst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .FB_SAMPLE(fb_s), .TGT_SAMPLE(tgt_s), .BASE_FREQ(base_f),
      .DI_RAMP_OFF(di_ramp_off), .DI_GAIN_ALT(di_gain_alt),
      .DI_SLEEP_EN(di_sleep_en), .RTC_ACTIVE(rtc_active),
      .FREQ_REF(freq_ref), .REVERSE(reverse), .RUN_CMD(run_cmd),
      .FAULT_CONTACT(fault_contact), .LOSS_WARN(loss_warn),
      .LOSS_FAULT(loss_fault), .SRC_ALARM(src_alarm),
      .SLEEPING(sleeping), .DISP_FB(disp_fb));

   pps_drive_model u_drv (
      .clk(clk), .rst(sys_rst), .freq_ref(freq_ref), .run_cmd(run_cmd),
      .fb_level(fb_level), .tgt_level(tgt_level), .base_level(base_level),
      .fb_sample(fb_s), .tgt_sample(tgt_s), .base_freq(base_f),
      .motor_freq(motor_f));

   task end_sim();
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task cf(input logic [15:0] e);
      chk("freq_ref", 32'(freq_ref), 32'(e));
   endtask

   task ws(input int n);
      repeat (n * SC) @(posedge clk);
   endtask

   task wr(input logic [4:0] i, input logic [31:0] d);
      logic done;
      @(posedge clk);
      awaddr <= {1'b0, i, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task rd(input logic [4:0] i);
      logic done;
      @(posedge clk);
      araddr <= {1'b0, i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready) begin
            rdat = rdata;
            resp = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end

   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (int k = 0; k < 6; k++) begin
         rd(ri[k]);
         chk("reset value", rdat, rv[k]);
      end
      rd(5'h1c);
      chk("unmapped rresp", 32'(resp), 32'(RESP_ERR));
      chk("unmapped rdata", rdat, 32'h0000_0000);
      wr(5'h1c, 32'h0000_1234);
      chk("unmapped bresp", 32'(resp), 32'(RESP_ERR));
      for (int k = 0; k < 8; k++)
         wr(ci[k], cv[k]);
      // Controller off: drive reference passes straight through
      base_level <= 16'h04d2;
      wr(REG_CTRL, 32'h0000_0000);
      ws(2);
      cf(16'h04d2);
      wr(REG_SEL, 32'h0000_0480);
      ws(2);
      chk("src_alarm", 32'(src_alarm), 32'h0000_0001);
      wr(REG_SEL, B);
      ws(2);
      chk("src_alarm", 32'(src_alarm), 32'h0000_0000);
      wr(REG_OLIM, 32'h0000_0bb8);
      wr(REG_CTRL, 32'h0000_0001);
      ws(3);
      cf(16'h0bb8);
      wr(REG_OLIM, 32'h0000_2710);
      wr(REG_TLIM, 32'h1388_0000);
      ws(3);
      cf(16'h1388);
      fb_level <= 16'h03e8;
      wr(REG_FBGAIN, 32'h0000_0200);
      ws(3);
      cf(16'h0bb8);
      fb_level <= 16'h0000;
      wr(REG_FBGAIN, 32'h0000_0100);
      for (int k = 0; k < 5; k++) begin
         di_gain_alt <= gd[k];
         rtc_active <= gr[k];
         wr(REG_SEL, B | {26'h0, gm[k], 4'h0});
         ws(3);
         cf(ge[k]);
      end
      wr(REG_SEL, B);
      wr(REG_CTRL, 32'h0000_0003);
      ws(3);
      cf(16'h0000);
      chk("reverse", 32'(reverse), 32'h0000_0000);
      wr(REG_SEL, B | 32'h0000_0800);
      ws(3);
      chk("reverse", 32'(reverse), 32'h0000_0001);
      wr(REG_SEL, B);
      wr(REG_CTRL, 32'h0000_0001);
      wr(REG_TLIM, RST_TLIM);
      tgt_level <= 16'h07d0;
      ws(3);
      cf(16'h07d0);
      di_ramp_off <= 1'b0;
      wr(REG_RAMP, 32'h0000_03e8);
      tgt_level <= 16'h1770;
      ws(2);
      chk("ramp", 32'(freq_ref > 16'h07d0 && freq_ref < 16'h1770),
          32'h0000_0001);
      ws(6);
      cf(16'h1770);
      wr(REG_LOSSLV, 32'h0000_07d0);
      wr(REG_LOSST, 32'h0000_0003);
      wr(REG_FALLBK, 32'h0000_05dc);
      wr(REG_SEL, B | 32'h0000_0001);
      ws(6);
      chk("loss_warn", 32'(loss_warn), 32'h0000_0001);
      chk("run_cmd", 32'(run_cmd), 32'h0000_0001);
      cf(16'h05dc);
      fb_level <= 16'h0bb8;
      ws(3);
      chk("loss_warn", 32'(loss_warn), 32'h0000_0000);
      cf(16'h0bb8);
      wr(REG_DISP, 32'h0200_0064);
      ws(2);
      chk("disp_fb", 32'(disp_fb), 32'h0000_17d4);
      rd(REG_DFB);
      chk("disp reg", rdat, 32'h0000_17d4);
      fb_level <= 16'h0000;
      wr(REG_SEL, B | 32'h0000_0002);
      ws(6);
      chk("loss_fault", 32'(loss_fault), 32'h0000_0001);
      chk("fault_contact", 32'(fault_contact), 32'h0000_0001);
      chk("run_cmd", 32'(run_cmd), 32'h0000_0000);
      fb_level <= 16'h0bb8;
      ws(2);
      chk("loss_fault", 32'(loss_fault), 32'h0000_0001);
      wr(REG_CTRL, 32'h0000_0000);
      ws(2);
      chk("loss_fault", 32'(loss_fault), 32'h0000_0000);
      wr(REG_SEL, B | 32'h0000_0004);
      wr(REG_SLPF, 32'h0000_0fa0);
      wr(REG_SLPT, 32'h0000_0002);
      wr(REG_WAKF, 32'h0000_2328);
      wr(REG_WAKT, 32'h0000_0002);
      wr(REG_CTRL, 32'h0000_0001);
      ws(8);
      chk("sleeping", 32'(sleeping), 32'h0000_0001);
      cf(16'h0000);
      fb_level <= 16'h0000;
      wr(REG_WAKF, 32'h0000_1388);
      ws(5);
      chk("sleeping", 32'(sleeping), 32'h0000_0000);
      cf(16'h1770);
      fb_level <= 16'h0bb8;
      ws(5);
      chk("sleeping", 32'(sleeping), 32'h0000_0001);
      wr(REG_SEL, B);
      ws(2);
      chk("sleeping", 32'(sleeping), 32'h0000_0000);
      wr(REG_BIAS, 32'h0000_03e8);
      wr(REG_OGAIN, 32'h0000_0200);
      ws(2);
      cf(16'h1388);
      wr(REG_BIAS, 32'h0000_0000);
      wr(REG_TGT, 32'h0000_1388);
      wr(REG_SEL, 32'h0000_0500);
      ws(3);
      cf(16'h07d0);
      wr(REG_ILIM, 32'h0000_01f4);
      wr(REG_I1, 32'h0000_0100);
      ws(3);
      cf(16'h09c4);
      rd(REG_FREQ);
      chk("freq reg", rdat, 32'h0000_09c4);
      ws(4);
      chk("motor_freq", 32'(motor_f), 32'h0000_09c4);
      end_sim();
   end
endmodule

// [verilog/pps_top.sv]
// PID supervisor: ramped target, scaled feedback, PID with two gain sets,
// limits, filter, bias, feedback loss watch and sleep/wake timers.
// Assumes synchronous inputs and an AXI4-Lite master on the register bus.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// Functional notes
// - Controller acts only when enable bit set
// - Error is target minus scaled feedback
// - Proportional term is error times gain
// - Polarity bit set gives reverse action
// - Raw feedback multiplied by feedback gain
// - Integral term clamped to integral limit
// - Summed output clamped to output limit
// - First-order low-pass after output limit
// - Bias times output gain added as compensation
// - Negative output held zero unless reversal allowed
// - Target ramped, bypassed by ramp-off input
// - Loss when feedback below level for time
// - Warning selection flags loss, keeps running
// - Fault selection flags loss, stops, fault contact
// - Fallback frequency while warning, then resume
// - Sleep after low frequency for sleep delay
// - Wake after reference above wake for delay
// - Sleep selection off, thresholds, or input
// - Alarm when target and feedback sources match
// - Target clamped between lower and upper limits
// - Gain set chosen by switching selection
// - Display value from display bias and gain
// - Reversal selection zero refuses negative output
// - Derivative on feedback or on error
module pps_top #(
   parameter int SAMPLE_CYC = pps_pkg::SAMPLE_CYC
) (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic [15:0] FB_SAMPLE,
   input  wire logic [15:0] TGT_SAMPLE,
   input  wire logic [15:0] BASE_FREQ,
   input  wire logic        DI_RAMP_OFF,
   input  wire logic        DI_GAIN_ALT,
   input  wire logic        DI_SLEEP_EN,
   input  wire logic        RTC_ACTIVE,
   output logic [15:0]      FREQ_REF,
   output logic             REVERSE,
   output logic             RUN_CMD,
   output logic             FAULT_CONTACT,
   output logic             LOSS_WARN,
   output logic             LOSS_FAULT,
   output logic             SRC_ALARM,
   output logic             SLEEPING,
   output logic [15:0]      DISP_FB
);
   import pps_pkg::*;

   pps_state_s s_r;
   pps_state_s s_nxt;

   function automatic logic signed [31:0] mulq(
      input logic signed [31:0] a,
      input logic [15:0]        g);
      logic signed [47:0] p;
      p = a * $signed({16'h0000, g});
      return 32'(p >>> 8);
   endfunction

   function automatic logic signed [15:0] clamp(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
      logic signed [31:0] r;
      r = (v < lo) ? lo : ((v > hi) ? hi : v);
      return 16'(r);
   endfunction

   function automatic logic signed [31:0] fld(input logic [31:0] w);
      return 32'($signed(w[15:0]));
   endfunction

   logic [31:0] ctrl;
   logic [31:0] sel;
   logic        fire;
   assign ctrl = s_r.cfg[REG_CTRL];
   assign sel  = s_r.cfg[REG_SEL];
   assign fire = (s_r.tick == 16'h0000);

   always_comb begin
      logic               aw_go, w_go, ar_go, alt, slp_on, neg;
      logic [4:0]         ra;
      logic [1:0]         gsel, lsel, ssel;
      logic [15:0]        kp, ki, kd;
      logic signed [31:0] fbv, tr, tl, tg, err, dsrc, pid, o, lo, hi;
      logic signed [15:0] lim;
      s_nxt  = s_r;
      aw_go  = AWVALID & s_r.awrdy;
      w_go   = WVALID & s_r.wrdy;
      ar_go  = ARVALID & s_r.arrdy;
      ra     = ARADDR[6:2];
      alt    = 1'b0;
      slp_on = 1'b0;
      neg    = 1'b0;
      gsel   = sel[SEL_GAIN +: 2];
      lsel   = sel[SEL_LOSS +: 2];
      ssel   = sel[SEL_SLP +: 2];
      kp = 16'h0000;
      ki = 16'h0000;
      kd = 16'h0000;
      fbv = '0;
      tr = '0;
      tl = '0;
      tg = '0;
      err = '0;
      dsrc = '0;
      pid = '0;
      o = '0;
      lo = '0;
      hi = '0;
      lim = '0;

      // Write address and data may arrive in either order
      if (aw_go) begin
         s_nxt.awh = 1'b1;
         s_nxt.wa  = AWADDR[6:2];
      end
      if (w_go) begin
         s_nxt.wh = 1'b1;
         s_nxt.wd = WDATA;
         s_nxt.ws = WSTRB;
      end
      if (s_nxt.awh && s_nxt.wh && !s_r.bvalid) begin
         s_nxt.awh    = 1'b0;
         s_nxt.wh     = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = (s_nxt.wa <= REG_DFB) ? RESP_OK : RESP_ERR;
         if (s_nxt.wa < 5'(NCFG)) begin
            for (int b = 0; b < 4; b++) begin
               if (s_nxt.ws[b]) begin
                  s_nxt.cfg[s_nxt.wa][8*b +: 8] = s_nxt.wd[8*b +: 8];
               end
            end
         end
      end else if (s_r.bvalid && BREADY) begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awrdy = !s_nxt.awh && !s_nxt.bvalid;
      s_nxt.wrdy  = !s_nxt.wh && !s_nxt.bvalid;

      if (ar_go) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = (ra <= REG_DFB) ? RESP_OK : RESP_ERR;
         if (ra < 5'(NCFG)) begin
            s_nxt.rdata = s_r.cfg[ra];
         end else if (ra == REG_STAT) begin
            s_nxt.rdata = {26'h000_0000, s_r.st == PPS_ASLEEP, s_r.alarm,
                           s_r.fault, s_r.warn, s_r.rev, s_r.run};
         end else if (ra == REG_FREQ) begin
            s_nxt.rdata = {16'h0000, s_r.freq};
         end else if (ra == REG_DFB) begin
            s_nxt.rdata = {16'h0000, s_r.disp};
         end else begin
            s_nxt.rdata = 32'h0000_0000;
         end
      end else if (s_r.rvalid && RREADY) begin
         s_nxt.rvalid = 1'b0;
      end
      s_nxt.arrdy = !s_nxt.rvalid;

      // Control update once per sample period
      s_nxt.tick = fire ? 16'(SAMPLE_CYC - 1)
                        : s_r.tick - 16'h0001;
      if (fire) begin
         fbv = mulq(32'($signed({1'b0, FB_SAMPLE[14:0]})),
                    s_r.cfg[REG_FBGAIN][15:0]);
         s_nxt.fb = clamp(fbv, -32'sd32767, 32'sd32767);
         tr = (sel[SEL_TSRC +: 3] == TSRC_REG) ? fld(s_r.cfg[REG_TGT])
              : 32'($signed({1'b0, TGT_SAMPLE[14:0]}));
         lo = fld({16'h0000, s_r.cfg[REG_TLIM][15:0]});
         hi = fld({16'h0000, s_r.cfg[REG_TLIM][31:16]});
         tl = clamp(tr, lo, hi);
         tg = fld({16'h0000, s_r.tgt});
         if (DI_RAMP_OFF) begin
            tg = tl;
         end else if (tg + fld(s_r.cfg[REG_RAMP]) < tl) begin
            tg = tg + fld(s_r.cfg[REG_RAMP]);
         end else if (tg - fld(s_r.cfg[REG_RAMP]) > tl) begin
            tg = tg - fld(s_r.cfg[REG_RAMP]);
         end else begin
            tg = tl;
         end
         s_nxt.tgt = 16'(tg);
         err = tg - fld({16'h0000, s_nxt.fb});
         if (ctrl[CTRL_POL]) begin
            err = -err;
         end
         unique case (gsel)
            2'h0: alt = 1'b0;
            2'h1: alt = 1'b1;
            2'h2: alt = DI_GAIN_ALT;
            2'h3: alt = RTC_ACTIVE;
         endcase
         kp = alt ? s_r.cfg[REG_P2][15:0] : s_r.cfg[REG_P1][15:0];
         ki = alt ? s_r.cfg[REG_I2][15:0] : s_r.cfg[REG_I1][15:0];
         kd = alt ? s_r.cfg[REG_D2][15:0] : s_r.cfg[REG_D1][15:0];
         hi = fld(s_r.cfg[REG_ILIM]);
         s_nxt.integ = clamp(fld({16'h0000, s_r.integ}) + mulq(err, ki),
                             -hi, hi);
         dsrc = ctrl[CTRL_DFB] ? -fld({16'h0000, s_nxt.fb})
                : err;
         s_nxt.dprev = clamp(dsrc, -32'sd32767, 32'sd32767);
         pid = mulq(err, kp) + fld({16'h0000, s_nxt.integ})
               + mulq(dsrc - fld({16'h0000, s_r.dprev}), kd);
         hi = fld(s_r.cfg[REG_OLIM]);
         lim = clamp(pid, -hi, hi);
         s_nxt.filt = clamp(fld({16'h0000, s_r.filt})
            + mulq(fld({16'h0000, lim}) - fld({16'h0000, s_r.filt}),
                   s_r.cfg[REG_LPF][15:0]),
            -32'sd32767, 32'sd32767);
         o = fld({16'h0000, s_nxt.filt})
             + mulq(fld(s_r.cfg[REG_BIAS]),
                    s_r.cfg[REG_OGAIN][15:0]);
         if (ctrl[CTRL_ADDT]) begin
            o = o + tg;
         end
         neg = o < 0;
         if (neg && !sel[SEL_REV]) begin
            o = '0;
         end else if (neg) begin
            o = -o;
         end
         s_nxt.rev = neg && sel[SEL_REV] && ctrl[CTRL_EN];
         // Feedback loss watch
         if (s_nxt.fb < $signed(s_r.cfg[REG_LOSSLV][15:0])
             && lsel != 2'h0) begin
            if (s_r.loss_cnt != 16'hffff) begin
               s_nxt.loss_cnt = s_r.loss_cnt + 16'h0001;
            end
         end else begin
            s_nxt.loss_cnt = 16'h0000;
         end
         s_nxt.warn = lsel == 2'h1
                      && s_nxt.loss_cnt >= s_r.cfg[REG_LOSST][15:0]
                      && s_nxt.loss_cnt != 16'h0000;
         if (lsel == 2'h2 && s_nxt.loss_cnt != 16'h0000
             && s_nxt.loss_cnt >= s_r.cfg[REG_LOSST][15:0]) begin
            s_nxt.fault = 1'b1;
         end else if (!ctrl[CTRL_EN]) begin
            s_nxt.fault = 1'b0;
         end
         if (!ctrl[CTRL_EN]) begin
            s_nxt.freq = BASE_FREQ;
         end else if (s_nxt.warn) begin
            s_nxt.freq = s_r.cfg[REG_FALLBK][15:0];
         end else begin
            s_nxt.freq = 16'(o);
         end
         // Sleep and wake timers
         slp_on = ssel == 2'h1 || (ssel == 2'h2 && DI_SLEEP_EN);
         unique case (s_r.st)
            PPS_AWAKE: begin
               if (slp_on && s_nxt.freq < s_r.cfg[REG_SLPF][15:0]) begin
                  s_nxt.slp_cnt = s_r.slp_cnt + 16'h0001;
               end else begin
                  s_nxt.slp_cnt = 16'h0000;
               end
               if (s_nxt.slp_cnt > s_r.cfg[REG_SLPT][15:0]) begin
                  s_nxt.st      = PPS_ASLEEP;
                  s_nxt.slp_cnt = 16'h0000;
               end
            end
            PPS_ASLEEP: begin
               if (s_nxt.freq > s_r.cfg[REG_WAKF][15:0]) begin
                  s_nxt.slp_cnt = s_r.slp_cnt + 16'h0001;
               end else begin
                  s_nxt.slp_cnt = 16'h0000;
               end
               if (!slp_on || s_nxt.slp_cnt > s_r.cfg[REG_WAKT][15:0]) begin
                  s_nxt.st      = PPS_AWAKE;
                  s_nxt.slp_cnt = 16'h0000;
               end
            end
         endcase
         s_nxt.fref  = (s_nxt.st == PPS_ASLEEP) ? 16'h0000 : s_nxt.freq;
         s_nxt.run   = !s_nxt.fault && s_nxt.st == PPS_AWAKE;
         s_nxt.alarm = sel[SEL_TSRC +: 3]
                       == {1'b0, sel[SEL_FSRC +: 2]};
         s_nxt.disp  = 16'(fld(s_r.cfg[REG_DISP])
            + mulq(fld({16'h0000, s_nxt.fb}),
                   s_r.cfg[REG_DISP][31:16]));
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         s_r                  <= '0;
         s_r.cfg[REG_SEL]     <= RST_SEL;
         s_r.cfg[REG_FBGAIN]  <= RST_UNITY;
         s_r.cfg[REG_LPF]     <= RST_UNITY;
         s_r.cfg[REG_OGAIN]   <= RST_UNITY;
         s_r.cfg[REG_ILIM]    <= RST_FULL;
         s_r.cfg[REG_OLIM]    <= RST_FULL;
         s_r.cfg[REG_TLIM]    <= RST_TLIM;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign AWREADY       = s_r.awrdy;
   assign WREADY        = s_r.wrdy;
   assign BVALID        = s_r.bvalid;
   assign BRESP         = s_r.bresp;
   assign ARREADY       = s_r.arrdy;
   assign RVALID        = s_r.rvalid;
   assign RDATA         = s_r.rdata;
   assign RRESP         = s_r.rresp;
   assign FREQ_REF      = s_r.fref;
   assign REVERSE       = s_r.rev;
   assign RUN_CMD       = s_r.run;
   assign FAULT_CONTACT = s_r.fault;
   assign LOSS_WARN     = s_r.warn;
   assign LOSS_FAULT    = s_r.fault;
   assign SRC_ALARM     = s_r.alarm;
   assign SLEEPING      = s_r.st == PPS_ASLEEP;
   assign DISP_FB       = s_r.disp;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence wr_both;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence resp_up;
      ##1 BVALID && !AWREADY;
   endsequence

   a_write_resp: assert property (wr_both |-> resp_up)
      else $error("write response missing");
   a_read_resp: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
      else $error("read response missing");
   a_disabled_ref: assert property (fire && !ctrl[CTRL_EN]
      |=> s_r.freq == $past(BASE_FREQ))
      else $error("disabled output not base frequency");
   a_integ_bound: assert property (fire |=>
      s_r.integ <= $signed($past(s_r.cfg[REG_ILIM][15:0]))
      && s_r.integ >= -$signed($past(s_r.cfg[REG_ILIM][15:0])))
      else $error("integral out of limit");
   a_no_reverse: assert property (fire && !sel[SEL_REV]
      |=> !REVERSE)
      else $error("reverse while disallowed");
   a_fault_stop: assert property (LOSS_FAULT |-> !RUN_CMD && FAULT_CONTACT)
      else $error("fault without stop");
   a_warn_fallbk: assert property (fire && ctrl[CTRL_EN]
      ##1 s_r.warn |-> s_r.freq == $past(s_r.cfg[REG_FALLBK][15:0]))
      else $error("fallback frequency not applied");
   a_src_alarm: assert property (fire |=> SRC_ALARM ==
      ($past(sel[SEL_TSRC +: 3]) == {1'b0, $past(sel[SEL_FSRC +: 2])}))
      else $error("source conflict alarm wrong");
   a_tick_period: assert property (fire |=> !fire [*3])
      else $error("sample tick too early");
   a_sleep_zero: assert property (SLEEPING |-> FREQ_REF == 16'h0000)
      else $error("frequency output while asleep");
endmodule
